// ===== src/rff_pkg.sv
package rff_pkg;
    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 40;
    localparam int BYTE_W = 8;
    localparam logic [7:0] ADDR_FILL = 8'h17;
    localparam logic [7:0] ADDR_VARLEN = 8'h1c;
    localparam logic [7:0] ADDR_OPTION = 8'h1d;
    localparam logic [7:0] ADDR_SETTLE = 8'h1e;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;

    // queue fill flags layout
    localparam int FILL_RX_EMPTY = 0;
    localparam int FILL_RX_FULL = 1;
    localparam int FILL_TX_EMPTY = 4;
    localparam int FILL_TX_FULL = 5;
    localparam int FILL_REUSED = 6;
    localparam logic [7:0] FILL_RESERVED = 8'h8c;
    localparam logic [7:0] FILL_RESET = 8'h11;

    // per-pipe variable length enables
    localparam int PIPE_COUNT = 6;
    localparam logic [7:0] VARLEN_RESERVED = 8'hc0;
    localparam logic [5:0] VARLEN_RESET = 6'h00;

    // protocol option enables
    localparam int OPT_W = 3;
    localparam int OPT_NOACK = 0;
    localparam int OPT_ACK_PAY = 1;
    localparam int OPT_GLOBAL_VL = 2;
    localparam logic [7:0] OPT_RESERVED = 8'hf8;
    localparam logic [2:0] OPT_RESET = 3'h0;

    // radio settle timers, five byte lanes
    localparam int SETTLE_LANES = 5;
    localparam logic [39:0] SETTLE_RESET = 40'h00_1080_3228;
    localparam int RX_SETUP_LSB = 0;

    // one timer step and its length in core clock cycles
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_NS = 1000;
    localparam logic [15:0] CYCLES_PER_STEP = 16'(STEP_NS / CLK_PERIOD_NS);
    localparam int CYC_W = 16;

    // interrupt sources
    localparam int IRQ_W = 4;
    localparam int IRQ_TX_FULL = 0;
    localparam int IRQ_RX_ARRIVE = 1;
    localparam int IRQ_NOACK_REJECT = 2;
    localparam int IRQ_TX_DRAINED = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
endpackage : rff_pkg

// ===== src/rff_settle_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rff_settle_if;
    logic wr;
    logic [39:0] wdata;
    logic [39:0] value;
    modport bank (input wr, input wdata, output value);
    modport ctrl (output wr, output wdata, input value);
endinterface : rff_settle_if
`default_nettype wire

// ===== src/rff_settle_bank.sv
`timescale 1ns/1ps
`default_nettype none
module rff_settle_bank (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // register side
    rff_settle_if.bank bus
);
    import rff_pkg::*;

    logic [BYTE_W-1:0] lane [SETTLE_LANES];

    // each lane keeps its own reset value, all lanes load together
    for (genvar g = 0; g < SETTLE_LANES; g++) begin : g_lane
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                lane[g] <= SETTLE_RESET[g*BYTE_W +: BYTE_W]; // RULE8
            end else if (bus.wr) begin
                lane[g] <= bus.wdata[g*BYTE_W +: BYTE_W];
            end
        end
        assign bus.value[g*BYTE_W +: BYTE_W] = lane[g];
    end
endmodule : rff_settle_bank
`default_nettype wire

// ===== src/rff_regs.sv
// Functional notes
// (RULE1) tx queue full at bit 5, empty at bit 4; reset shows 0 and 1.
// (RULE2) rx queue full at bit 1, empty at bit 0; reset shows 0 and 1.
// (RULE3) reserved bits written 1 restore defaults; written 0 keep the value.
// (RULE4) six per-pipe variable length enables, reset 0, gated by the global enable.
// (RULE5) global variable length enable at option bit 2, reset 0.
// (RULE6) option bit 1 lets acknowledgements carry a payload, reset 0.
// (RULE7) no-acknowledge payload command accepted only while option bit 0 is set.
// (RULE8) lowest settle byte is standby-to-receive delay in 1 us steps, reset 8'h28.
// (RULE9) read-only payload reuse flag at fill flags bit 6, reset 0.
`timescale 1ns/1ps
`default_nettype none
module rff_regs (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    // register port
    input wire logic [rff_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [rff_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [rff_pkg::DATA_W-1:0] O_RDATA,
    // queue state from the packet engine
    input wire logic I_TX_FULL,
    input wire logic I_TX_EMPTY,
    input wire logic I_RX_FULL,
    input wire logic I_RX_EMPTY,
    input wire logic I_TX_PAYLOAD_REUSED,
    output logic O_QUEUE_RESTORE,
    // no-acknowledge command gate
    input wire logic I_NOACK_CMD,
    output logic O_NOACK_ACCEPT,
    output logic O_NOACK_REJECT,
    // settings to the packet engine
    output logic [rff_pkg::PIPE_COUNT-1:0] O_VAR_LEN_PIPE,
    output logic O_GLOBAL_VAR_LEN_ENABLE,
    output logic O_ACK_PAYLOAD_ENABLE,
    output logic O_NOACK_COMMAND_ENABLE,
    output logic [rff_pkg::DATA_W-1:0] O_SETTLE_TIMERS,
    output logic [rff_pkg::CYC_W-1:0] O_RX_SETUP_CYCLES,
    // interrupt
    output logic O_IRQ
);
    import rff_pkg::*;

    rff_settle_if settle ();

    logic [7:0] fill;
    logic [PIPE_COUNT-1:0] varlen;
    logic [OPT_W-1:0] option;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic queue_restore;
    logic noack_accept;
    logic noack_reject;
    logic [PIPE_COUNT-1:0] pipe_eff;
    logic [CYC_W-1:0] rx_setup_cycles;

    // address decode
    wire sel_fill = (I_ADDR == ADDR_FILL);
    wire sel_varlen = (I_ADDR == ADDR_VARLEN);
    wire sel_option = (I_ADDR == ADDR_OPTION);
    wire sel_settle = (I_ADDR == ADDR_SETTLE);
    wire sel_status = (I_ADDR == ADDR_IRQ_STATUS);
    wire sel_mask = (I_ADDR == ADDR_IRQ_MASK);

    // a one in any reserved position asks for the register's defaults
    wire fill_restore = |(I_WDATA[7:0] & FILL_RESERVED); // RULE3
    wire varlen_restore = |(I_WDATA[7:0] & VARLEN_RESERVED); // RULE3
    wire option_restore = |(I_WDATA[7:0] & OPT_RESERVED); // RULE3

    wire wr_fill = I_WR && sel_fill;
    wire wr_varlen = I_WR && sel_varlen;
    wire wr_option = I_WR && sel_option;
    wire wr_mask = I_WR && sel_mask;
    wire rd_status = I_RD && sel_status;

    wire [PIPE_COUNT-1:0] next_varlen = varlen_restore ? VARLEN_RESET : I_WDATA[PIPE_COUNT-1:0];
    wire [OPT_W-1:0] next_option = option_restore ? OPT_RESET : I_WDATA[OPT_W-1:0];

    // live view of the queues; sampled so reset shows the documented pattern
    wire [7:0] next_fill = {1'b0, I_TX_PAYLOAD_REUSED, I_TX_FULL, I_TX_EMPTY,
                            2'b00, I_RX_FULL, I_RX_EMPTY};

    // interrupt sources are edges of the sampled flags plus a refused command
    wire [IRQ_W-1:0] irq_event;
    assign irq_event[IRQ_TX_FULL] = next_fill[FILL_TX_FULL] && !fill[FILL_TX_FULL];
    assign irq_event[IRQ_RX_ARRIVE] = !next_fill[FILL_RX_EMPTY] && fill[FILL_RX_EMPTY];
    assign irq_event[IRQ_NOACK_REJECT] = I_NOACK_CMD && !option[OPT_NOACK];
    assign irq_event[IRQ_TX_DRAINED] = next_fill[FILL_TX_EMPTY] && !fill[FILL_TX_EMPTY];

    // set beats the read clear, so an event in the read cycle stays pending
    wire [IRQ_W-1:0] next_irq_status = (irq_status & ~{IRQ_W{rd_status}}) | irq_event;

    // read mux, unmapped addresses answer zero
    wire [DATA_W-1:0] rd_mux =
        sel_fill ? DATA_W'(fill) :
        sel_varlen ? DATA_W'(varlen) :
        sel_option ? DATA_W'(option) :
        sel_settle ? settle.value :
        sel_status ? DATA_W'(irq_status) :
        sel_mask ? DATA_W'(irq_mask) : '0;

    assign pipe_eff = varlen & {PIPE_COUNT{option[OPT_GLOBAL_VL]}}; // RULE4

    assign settle.wr = I_WR && sel_settle; // RULE8
    assign settle.wdata = I_WDATA;

    rff_settle_bank u_settle (
        .i_clk(I_CORE_CLK),
        .i_rst_b(I_RST_B),
        .bus(settle.bank)
    );

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            fill <= FILL_RESET; // RULE1 RULE2 RULE9
        end else begin
            fill <= next_fill; // RULE1 RULE2 RULE9
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            varlen <= VARLEN_RESET;
            option <= OPT_RESET;
        end else begin
            if (wr_varlen) begin
                varlen <= next_varlen; // RULE4
            end
            if (wr_option) begin
                option <= next_option; // RULE5 RULE6 RULE7
            end
        end
    end

    // fill flags are read-only; a reserved one only asks the queues to restore
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            queue_restore <= 1'b0;
        end else begin
            queue_restore <= wr_fill && fill_restore; // RULE3
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            noack_accept <= 1'b0;
            noack_reject <= 1'b0;
        end else begin
            noack_accept <= I_NOACK_CMD && option[OPT_NOACK]; // RULE7
            noack_reject <= I_NOACK_CMD && !option[OPT_NOACK]; // RULE7
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            irq_status <= IRQ_STATUS_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            irq_status <= next_irq_status;
            if (wr_mask) begin
                irq_mask <= I_WDATA[IRQ_W-1:0];
            end
        end
    end

    // read data and the rx setup cycle count retimed once so neither shows a decode glitch
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_B) begin
            rdata <= '0;
            rx_setup_cycles <= '0;
        end else begin
            rdata <= I_RD ? rd_mux : '0;
            rx_setup_cycles <= CYC_W'(CYC_W'(settle.value[RX_SETUP_LSB +: BYTE_W]) * CYCLES_PER_STEP); // RULE8
        end
    end

    assign O_RDATA = rdata;
    assign O_QUEUE_RESTORE = queue_restore;
    assign O_NOACK_ACCEPT = noack_accept;
    assign O_NOACK_REJECT = noack_reject;
    assign O_VAR_LEN_PIPE = pipe_eff;
    assign O_GLOBAL_VAR_LEN_ENABLE = option[OPT_GLOBAL_VL]; // RULE5
    assign O_ACK_PAYLOAD_ENABLE = option[OPT_ACK_PAY]; // RULE6
    assign O_NOACK_COMMAND_ENABLE = option[OPT_NOACK]; // RULE7
    assign O_SETTLE_TIMERS = settle.value;
    assign O_RX_SETUP_CYCLES = rx_setup_cycles;
    assign O_IRQ = |(irq_status & irq_mask);

    // checks

    property p_tx_flags;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_RD && sel_fill && $past(I_RST_B)) |=>
            (O_RDATA[FILL_TX_FULL] == $past(I_TX_FULL, 2)) &&
            (O_RDATA[FILL_TX_EMPTY] == $past(I_TX_EMPTY, 2));
    endproperty
    a_tx_flags: assert property (p_tx_flags) else $error("tx fill flags read wrong"); // RULE1

    property p_rx_flags;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_RD && sel_fill && $past(I_RST_B)) |=>
            (O_RDATA[FILL_RX_FULL] == $past(I_RX_FULL, 2)) &&
            (O_RDATA[FILL_RX_EMPTY] == $past(I_RX_EMPTY, 2));
    endproperty
    a_rx_flags: assert property (p_rx_flags) else $error("rx fill flags read wrong"); // RULE2

    property p_fill_reset;
        @(posedge I_CORE_CLK)
        $rose(I_RST_B) |-> (fill == FILL_RESET) ##1 (fill == $past(next_fill));
    endproperty
    a_fill_reset: assert property (p_fill_reset) else $error("fill flags wrong after reset"); // RULE1

    property p_reserved_restore;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        ((wr_varlen && varlen_restore) || (wr_option && option_restore)) |=>
            ($past(wr_varlen) ? (varlen == VARLEN_RESET) : (option == OPT_RESET));
    endproperty
    a_reserved_restore: assert property (p_reserved_restore) else $error("reserved write kept value"); // RULE3

    property p_queue_restore;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (wr_fill && fill_restore) |=> O_QUEUE_RESTORE ##1 !O_QUEUE_RESTORE || $past(wr_fill);
    endproperty
    a_queue_restore: assert property (p_queue_restore) else $error("restore request missing"); // RULE3

    property p_pipe_gate;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (wr_varlen && !varlen_restore && !wr_option) |=>
            O_VAR_LEN_PIPE == ($past(I_WDATA[PIPE_COUNT-1:0]) & {PIPE_COUNT{O_GLOBAL_VAR_LEN_ENABLE}});
    endproperty
    a_pipe_gate: assert property (p_pipe_gate) else $error("pipe enable not gated"); // RULE4

    property p_global_enable;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (wr_option && !option_restore) |=>
            (O_GLOBAL_VAR_LEN_ENABLE == $past(I_WDATA[OPT_GLOBAL_VL])) &&
            (O_VAR_LEN_PIPE == (varlen & {PIPE_COUNT{$past(I_WDATA[OPT_GLOBAL_VL])}}));
    endproperty
    a_global_enable: assert property (p_global_enable) else $error("global enable write lost"); // RULE5

    property p_ack_payload;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !wr_option |=> $stable(O_ACK_PAYLOAD_ENABLE);
    endproperty
    a_ack_payload: assert property (p_ack_payload) else $error("ack payload enable moved"); // RULE6

    property p_noack_gate;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        I_NOACK_CMD |=> (O_NOACK_ACCEPT == $past(O_NOACK_COMMAND_ENABLE)) &&
            (O_NOACK_REJECT == !$past(O_NOACK_COMMAND_ENABLE)) &&
            (O_NOACK_ACCEPT || irq_status[IRQ_NOACK_REJECT]);
    endproperty
    a_noack_gate: assert property (p_noack_gate) else $error("noack command gate wrong"); // RULE7

    property p_rx_setup;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (settle.wr && $past(I_RST_B)) |=> (O_SETTLE_TIMERS[BYTE_W-1:0] == $past(I_WDATA[BYTE_W-1:0]))
            ##1 (O_RX_SETUP_CYCLES == CYC_W'($past(I_WDATA[BYTE_W-1:0], 2) * CYCLES_PER_STEP));
    endproperty
    a_rx_setup: assert property (p_rx_setup) else $error("rx setup delay wrong"); // RULE8

    property p_reuse_flag;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_RD && sel_fill && $past(I_RST_B)) |=>
            (O_RDATA[FILL_REUSED] == $past(I_TX_PAYLOAD_REUSED, 2)) && !O_RDATA[7];
    endproperty
    a_reuse_flag: assert property (p_reuse_flag) else $error("reuse flag read wrong"); // RULE9

    property p_irq_sticky;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (|irq_event) |=> ((irq_status & $past(irq_event)) == $past(irq_event));
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt event lost");

    property p_rdata_idle;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !I_RD |=> (O_RDATA == '0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero between reads");

    property p_unmapped_read;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_RD && !(sel_fill || sel_varlen || sel_option || sel_settle || sel_status || sel_mask)) |=>
            (O_RDATA == '0);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    property p_fill_gaps;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (I_RD && sel_fill) |=> (O_RDATA[DATA_W-1:FILL_REUSED+1] == '0) &&
            (O_RDATA[FILL_TX_EMPTY-1:FILL_RX_FULL+1] == '0);
    endproperty
    a_fill_gaps: assert property (p_fill_gaps) else $error("reserved fill bits read nonzero"); // RULE3

    property p_varlen_store;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (wr_varlen && !varlen_restore) |=> (varlen == $past(I_WDATA[PIPE_COUNT-1:0]));
    endproperty
    a_varlen_store: assert property (p_varlen_store) else $error("pipe enables not stored"); // RULE4

    property p_varlen_hold;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !wr_varlen |=> $stable(varlen);
    endproperty
    a_varlen_hold: assert property (p_varlen_hold) else $error("pipe enables moved"); // RULE4

    property p_option_store;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        (wr_option && !option_restore) |=>
            ({O_GLOBAL_VAR_LEN_ENABLE, O_ACK_PAYLOAD_ENABLE, O_NOACK_COMMAND_ENABLE} == $past(I_WDATA[OPT_W-1:0]));
    endproperty
    a_option_store: assert property (p_option_store) else $error("option bits not stored"); // RULE6

    property p_noack_enable_hold;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !wr_option |=> $stable(O_NOACK_COMMAND_ENABLE) && $stable(O_GLOBAL_VAR_LEN_ENABLE);
    endproperty
    a_noack_enable_hold: assert property (p_noack_enable_hold) else $error("option enables moved"); // RULE7

    property p_settle_hold;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !settle.wr |=> $stable(O_SETTLE_TIMERS);
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("settle timers moved"); // RULE8

    property p_status_clear;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        rd_status |=> (irq_status == $past(irq_event));
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status read did not clear");

    property p_noack_single;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !I_NOACK_CMD |=> !O_NOACK_ACCEPT && !O_NOACK_REJECT;
    endproperty
    a_noack_single: assert property (p_noack_single) else $error("noack answer without command"); // RULE7

    property p_restore_idle;
        @(posedge I_CORE_CLK) disable iff (!I_RST_B)
        !(wr_fill && fill_restore) |=> !O_QUEUE_RESTORE;
    endproperty
    a_restore_idle: assert property (p_restore_idle) else $error("restore request without write"); // RULE3

    property p_reset_defaults;
        @(posedge I_CORE_CLK)
        $rose(I_RST_B) |-> (varlen == VARLEN_RESET) && (option == OPT_RESET) &&
            (O_SETTLE_TIMERS == SETTLE_RESET) && (irq_status == IRQ_STATUS_RESET) && !O_IRQ;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("defaults missing after reset"); // RULE4
endmodule : rff_regs
`default_nettype wire

// ===== bench/radio_fifo_protocol_option_enables_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) check_eq(40'(act), 40'(exp))
module radio_fifo_protocol_option_enables_regs_tb_top;
    import rff_pkg::*;
    // stimulus, all given a value at time zero
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [39:0] wdata = 40'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tx_full = 1'b0;
    logic tx_empty = 1'b1;
    logic rx_full = 1'b0;
    logic rx_empty = 1'b1;
    logic reused = 1'b0;
    logic noack_cmd = 1'b0;
    // observed outputs
    logic [39:0] rdata;
    logic restore, acc, rej, gvl, ackp, noen, irq;
    logic [5:0] vlp;
    logic [39:0] settle;
    logic [15:0] rxcyc;
    // scoreboard
    logic [39:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [31:0] r;
    logic [5:0] vl;
    logic [39:0] sv;
    logic [7:0] rsv [3] = '{8'h80, 8'h08, 8'h04};
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'hc796;

    rff_regs u_dut (
        .I_CORE_CLK(clk), .I_RST_B(rst_b),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .I_TX_FULL(tx_full), .I_TX_EMPTY(tx_empty), .I_RX_FULL(rx_full), .I_RX_EMPTY(rx_empty),
        .I_TX_PAYLOAD_REUSED(reused), .O_QUEUE_RESTORE(restore),
        .I_NOACK_CMD(noack_cmd), .O_NOACK_ACCEPT(acc), .O_NOACK_REJECT(rej),
        .O_VAR_LEN_PIPE(vlp), .O_GLOBAL_VAR_LEN_ENABLE(gvl), .O_ACK_PAYLOAD_ENABLE(ackp),
        .O_NOACK_COMMAND_ENABLE(noen), .O_SETTLE_TIMERS(settle), .O_RX_SETUP_CYCLES(rxcyc),
        .O_IRQ(irq)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_eq(input logic [39:0] act, input logic [39:0] exp);
        compares++;
        if (act !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : check_eq

    // strobes are raised one edge after the previous release, never in the same step
    task automatic reg_wr(input logic [7:0] a, input logic [39:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [39:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : reg_rd

    task automatic pulse_noack();
        @(posedge clk);
        noack_cmd <= 1'b1;
        @(posedge clk);
        noack_cmd <= 1'b0;
    endtask : pulse_noack

    // read data stand only in the cycle after the strobe, so compare exactly there
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rd_pend) begin
            `CHK(rdata, exp_q.pop_front());
        end
        rd_pend <= rd;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 `CHK(settle, SETTLE_RESET);
        reg_rd(ADDR_FILL, 40'h11);
        reg_rd(ADDR_VARLEN, 40'h0);
        reg_rd(ADDR_OPTION, 40'h0);
        reg_rd(ADDR_SETTLE, 40'h00_1080_3228);
        #1 `CHK(rxcyc, 16'h1f40);
        // interrupt: raise, clear by reading, then masked and unmasked
        reg_wr(ADDR_IRQ_MASK, 40'hf);
        #1 `CHK(irq, 1'b0);
        @(posedge clk);
        tx_full <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK(irq, 1'b1);
        reg_rd(ADDR_IRQ_STATUS, 40'h1);
        #1 `CHK(irq, 1'b0);
        reg_wr(ADDR_IRQ_MASK, 40'h0);
        pulse_noack();
        #1 `CHK({acc, rej}, 2'b01);
        `CHK(irq, 1'b0);
        reg_rd(ADDR_IRQ_MASK, 40'h0);
        reg_wr(ADDR_IRQ_MASK, 40'h4);
        #1 `CHK(irq, 1'b1);
        reg_rd(ADDR_IRQ_STATUS, 40'h4);
        // queue flags follow random queue states
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            @(posedge clk);
            {reused, tx_full, tx_empty, rx_full, rx_empty} <= r[4:0];
            reg_rd(ADDR_FILL, {33'h0, r[4], r[3], r[2], 2'b00, r[1], r[0]});
        end
        // read-only place: data bits store nothing, reserved ones ask for a restore
        reg_wr(ADDR_FILL, 40'h73);
        #1 `CHK(restore, 1'b0);
        reg_rd(ADDR_FILL, {33'h0, r[4], r[3], r[2], 2'b00, r[1], r[0]});
        foreach (rsv[i]) begin
            reg_wr(ADDR_FILL, 40'(rsv[i]));
            #1 `CHK(restore, 1'b1);
            @(posedge clk);
            #1 `CHK(restore, 1'b0);
        end
        // per-pipe enables only count while the global enable is set
        vl = 6'($random(seed));
        reg_wr(ADDR_VARLEN, 40'(vl));
        reg_rd(ADDR_VARLEN, 40'(vl));
        for (int o = 0; o < 8; o++) begin
            reg_wr(ADDR_OPTION, 40'(o));
            #1 `CHK(vlp, o[2] ? vl : 6'h0);
            `CHK({gvl, ackp, noen}, o[2:0]);
            reg_rd(ADDR_OPTION, 40'(o));
            pulse_noack();
            #1 `CHK({acc, rej}, {o[0], ~o[0]});
        end
        // reserved ones restore defaults even beside valid data
        reg_wr(ADDR_OPTION, 40'h0c);
        reg_rd(ADDR_OPTION, 40'h0);
        reg_wr(ADDR_VARLEN, 40'h40 | 40'(vl));
        reg_rd(ADDR_VARLEN, 40'h0);
        // unmapped place is ignored and reads zero
        reg_wr(8'h18, 40'hff);
        reg_rd(8'h18, 40'h0);
        reg_rd(ADDR_VARLEN, 40'h0);
        // settle timers are one whole 40-bit access
        sv = 40'({$random(seed), $random(seed)});
        reg_wr(ADDR_SETTLE, sv);
        #1 `CHK(settle, sv);
        reg_rd(ADDR_SETTLE, sv);
        #1 `CHK(rxcyc, 16'(sv[7:0]) * CYCLES_PER_STEP);
        // second reset in mid-run brings defaults back
        @(posedge clk);
        rst_b <= 1'b0;
        {reused, tx_full, tx_empty, rx_full, rx_empty} <= 5'b00101;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        reg_rd(ADDR_SETTLE, SETTLE_RESET);
        reg_rd(ADDR_OPTION, 40'h0);
        // queue edges raise their sticky bits, a read clears them
        @(posedge clk);
        {rx_empty, tx_empty} <= 2'b00;
        @(posedge clk);
        tx_empty <= 1'b1;
        reg_rd(ADDR_IRQ_STATUS, 40'ha);
        reg_rd(ADDR_IRQ_STATUS, 40'h0);
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule : radio_fifo_protocol_option_enables_regs_tb_top
`undef CHK
`default_nettype wire
